// ==== rtl/tpd_timer.sv ====
// Sixteen-bit PWM and input-capture timer with AXI4-Lite register access
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module tpd_timer
    import tpd_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Timer pins
    input  wire logic        timer_in,
    output logic             pwm_out,
    output logic             pwm_out_n,
    // Interrupt
    output logic             irq
);

    typedef struct packed {
        logic        en;
        tpd_mode_t   mode;
        logic        output_polarity;
        logic [2:0]  pre;
        logic [7:0]  db;
        logic [15:0] count;
        logic [15:0] reload;
        logic [15:0] match;
        logic [6:0]  presc;
        logic        pwm;
        logic        tin_prev;
        logic        input_capture_flag;
        logic [1:0]  status;
        logic [1:0]  int_en;
        logic        aw_held;
        logic [7:0]  awaddr;
        logic        w_held;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tpd_state_t;

    tpd_state_t s_q;
    tpd_state_t s_d;

    // Byte-lane merge of a write into a register image
    function automatic logic [31:0] tpd_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[8*i +: 8] = new_v[8*i +: 8];
        end
        return r;
    endfunction

    // Address decode, used for both read and write
    function automatic logic tpd_mapped(input logic [7:0] a);
        return (a == TPD_ADDR_CTRL) || (a == TPD_ADDR_COUNT) || (a == TPD_ADDR_RELOAD) ||
               (a == TPD_ADDR_MATCH) || (a == TPD_ADDR_STATUS) || (a == TPD_ADDR_INT_CLR) ||
               (a == TPD_ADDR_INT_EN);
    endfunction

    logic [31:0] ctrl_img;
    logic [31:0] stat_img;
    logic [31:0] wr_val;
    logic [6:0]  presc_lim;
    logic        tick;
    logic        at_reload;
    logic        at_match;
    logic        pwm_mode;
    logic        cap_edge;
    logic        do_write;
    logic        wr_count;
    logic        wr_match;
    logic [1:0]  ev_set;
    logic [1:0]  ev_clr;
    logic [1:0]  db_in;
    logic [1:0]  db_out;

    assign ctrl_img = {16'h0000, s_q.db, 1'b0, s_q.pre, s_q.output_polarity, s_q.mode, s_q.en};
    assign stat_img = {23'h0, s_q.input_capture_flag, 6'h0, s_q.status};

    // Divide by 2^pre; >= so a smaller prescale never waits for wrap
    assign presc_lim = 7'((8'h01 << s_q.pre) - 8'h01);
    assign tick      = s_q.en && (s_q.presc >= presc_lim);
    assign at_reload = tick && (s_q.count == s_q.reload);
    assign at_match  = tick && (s_q.count == s_q.match);
    assign pwm_mode  = (s_q.mode != TPD_MODE_CAPTURE);
    // Polarity 0 captures rising edges, polarity 1 falling
    assign cap_edge  = s_q.en && (s_q.mode == TPD_MODE_CAPTURE) &&
                       (s_q.output_polarity ? (s_q.tin_prev && !timer_in) : (!s_q.tin_prev && timer_in));

    // Write fires once both address and data have been taken
    assign do_write  = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    assign wr_count  = do_write && (s_q.awaddr == TPD_ADDR_COUNT);
    assign wr_match  = do_write && (s_q.awaddr == TPD_ADDR_MATCH);
    assign ev_set    = {cap_edge, at_reload};
    assign ev_clr    = (do_write && (s_q.awaddr == TPD_ADDR_INT_CLR)) ? s_q.wdata[1:0] : 2'b00;

    assign s_axi_awready = !s_q.aw_held && !s_q.bvalid;
    assign s_axi_wready  = !s_q.w_held && !s_q.bvalid;
    assign s_axi_arready = !s_q.rvalid;

    always_comb
    begin
        s_d    = s_q;
        wr_val = 32'h00000000;

        // Prescaler and counter
        if (!s_q.en)
            s_d.presc = '0;
        else if (tick)
            s_d.presc = '0;
        else
            s_d.presc = s_q.presc + 7'h01;

        // Restart at 0001H on reload, otherwise count up
        if (at_reload)
            s_d.count = TPD_COUNT_RESTART;
        else if (tick)
            s_d.count = s_q.count + 16'h0001;

        if (!s_q.en || at_reload)
            s_d.pwm = s_q.output_polarity;
        else if (at_match && pwm_mode)
            s_d.pwm = !s_q.pwm;

        s_d.tin_prev = timer_in;

        if (at_reload && (s_q.mode == TPD_MODE_CAPTURE))
            s_d.input_capture_flag = 1'b0;
        // Capture sets the flag, winning over a reload in the same cycle
        if (cap_edge)
            s_d.input_capture_flag = 1'b1;

        // Write channel capture
        if (s_axi_awvalid && s_axi_awready)
        begin
            s_d.aw_held = 1'b1;
            s_d.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            s_d.w_held = 1'b1;
            s_d.wdata  = s_axi_wdata;
            s_d.wstrb  = s_axi_wstrb;
        end

        if (do_write)
        begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = tpd_mapped(s_q.awaddr) ? TPD_RESP_OKAY : TPD_RESP_SLVERR;
            unique case (s_q.awaddr)
                TPD_ADDR_CTRL:
                begin
                    wr_val            = tpd_merge(ctrl_img, s_q.wdata, s_q.wstrb);
                    s_d.en            = wr_val[TPD_CTRL_EN_BIT];
                    s_d.mode          = tpd_mode_t'(wr_val[TPD_CTRL_MODE_LSB +: 2]);
                    s_d.output_polarity = wr_val[TPD_CTRL_POL_BIT];
                    s_d.pre           = wr_val[TPD_CTRL_PRE_LSB +: 3];
                    s_d.db            = (wr_val[TPD_CTRL_DB_LSB +: 8] > TPD_DB_MAX) ?
                                        TPD_DB_MAX : wr_val[TPD_CTRL_DB_LSB +: 8];
                end
                TPD_ADDR_COUNT:
                begin
                    // Software start value sets the first period
                    wr_val    = tpd_merge({16'h0000, s_q.count}, s_q.wdata, s_q.wstrb);
                    s_d.count = wr_val[15:0];
                end
                TPD_ADDR_RELOAD:
                begin
                    wr_val     = tpd_merge({16'h0000, s_q.reload}, s_q.wdata, s_q.wstrb);
                    s_d.reload = wr_val[15:0];
                end
                TPD_ADDR_MATCH:
                begin
                    wr_val    = tpd_merge({16'h0000, s_q.match}, s_q.wdata, s_q.wstrb);
                    s_d.match = wr_val[15:0];
                end
                TPD_ADDR_INT_EN:
                begin
                    wr_val     = tpd_merge({30'h0, s_q.int_en}, s_q.wdata, s_q.wstrb);
                    s_d.int_en = wr_val[1:0];
                end
                default:
                begin
                    wr_val = 32'h00000000;
                end
            endcase
        end

        // Capture copies count into match; overrides a software write
        if (cap_edge)
            s_d.match = s_q.count;

        // Sticky events: a new event wins over a clear
        s_d.status = (s_q.status & ~ev_clr) | ev_set;

        if (s_q.bvalid && s_axi_bready)
            s_d.bvalid = 1'b0;

        // Read channel, answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = tpd_mapped(s_axi_araddr) ? TPD_RESP_OKAY : TPD_RESP_SLVERR;
            unique case (s_axi_araddr)
                TPD_ADDR_CTRL:   s_d.rdata = ctrl_img;
                TPD_ADDR_COUNT:  s_d.rdata = {16'h0000, s_q.count};
                TPD_ADDR_RELOAD: s_d.rdata = {16'h0000, s_q.reload};
                TPD_ADDR_MATCH:  s_d.rdata = {16'h0000, s_q.match};
                TPD_ADDR_STATUS: s_d.rdata = stat_img;
                TPD_ADDR_INT_EN: s_d.rdata = {30'h0, s_q.int_en};
                default:         s_d.rdata = 32'h00000000;
            endcase
        end
        else if (s_q.rvalid && s_axi_rready)
        begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
        begin
            s_q        <= '0;
            s_q.mode   <= TPD_MODE_PWM_SINGLE;
            s_q.count  <= TPD_COUNT_RST;
            s_q.reload <= TPD_RELOAD_RST;
            s_q.match  <= TPD_MATCH_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Complement pin carries the inverse while enabled, dual mode only
    assign db_in[0] = pwm_mode && s_q.pwm;
    assign db_in[1] = (s_q.mode == TPD_MODE_PWM_DUAL) && s_q.en && !s_q.pwm;

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_db
            tpd_deadband #(
                .DBW     (8)
            ) u_db (
                .clock   (clock),
                .rst_b   (rst_b),
                .level_i (db_in[g]),
                .delay_i (s_q.db),
                .level_o (db_out[g])
            );
        end
    endgenerate

    // Single mode has no deadband on the primary pin: no complement to guard against
    assign pwm_out   = (s_q.mode == TPD_MODE_PWM_DUAL) ? db_out[0] : (pwm_mode && s_q.pwm);
    assign pwm_out_n = db_out[1];
    assign irq       = |(s_q.status & s_q.int_en);

    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp  = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata  = s_q.rdata;
    assign s_axi_rresp  = s_q.rresp;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence seq_reload_hit;
        tick && (s_q.count == s_q.reload) && !wr_count;
    endsequence

    sequence seq_plain_step;
        tick && (s_q.count != s_q.reload) && !wr_count;
    endsequence

    AST_RELOAD_RESTART: assert property (seq_reload_hit |=> (s_q.count == TPD_COUNT_RESTART) && s_q.status[0])
        else $error("Count did not restart at one on reload");

    AST_COUNT_STEP: assert property (seq_plain_step |=> s_q.count == $past(s_q.count) + 16'h0001)
        else $error("Count did not advance on tick");

    AST_HOLD_DISABLED: assert property (!s_q.en && !wr_count |=> $stable(s_q.count))
        else $error("Count moved while disabled");

    AST_PRESC_SPACING: assert property (tick && s_q.pre == 3'h2 && $stable(s_q.pre) |=> !tick [*3])
        else $error("Prescale four ticked too early");

    AST_MATCH_TOGGLE: assert property (at_match && !at_reload && pwm_mode && s_q.en
                                       |=> s_q.pwm != $past(s_q.pwm))
        else $error("Output did not toggle on match");

    AST_POL1_RELOAD: assert property (at_reload && s_q.output_polarity |=> s_q.pwm)
        else $error("Polarity one output not high after reload");

    AST_POL0_RELOAD: assert property (at_reload && !s_q.output_polarity |=> !s_q.pwm)
        else $error("Polarity zero output not low after reload");

    AST_NO_OVERLAP: assert property (s_q.mode == TPD_MODE_PWM_DUAL |-> !(pwm_out && pwm_out_n))
        else $error("Both outputs high together");

    AST_COMPL_FALL: assert property (s_q.mode == TPD_MODE_PWM_DUAL && $stable(s_q.mode) && s_q.en && $rose(s_q.pwm)
                                     |=> !pwm_out_n)
        else $error("Complement not released after primary rose");

    AST_CAPTURE_COPY: assert property (cap_edge |=> s_q.match == $past(s_q.count) && s_q.input_capture_flag)
        else $error("Capture did not copy count or set flag");

    AST_CAPTURE_IRQ: assert property (cap_edge |=> s_q.status[1])
        else $error("Capture did not raise event");

    AST_CAPTURE_RISE: assert property (s_q.en && s_q.mode == TPD_MODE_CAPTURE && !s_q.output_polarity &&
                                       !s_q.tin_prev && timer_in |=> s_q.status[1] && s_q.input_capture_flag)
        else $error("Rising edge not captured with polarity zero");

    AST_CAP_RELOAD_CLR: assert property (at_reload && s_q.mode == TPD_MODE_CAPTURE && !cap_edge
                                         |=> !s_q.input_capture_flag && s_q.status[0])
        else $error("Reload did not clear capture flag");

endmodule // tpd_timer

// ==== rtl/tpd_pkg.sv ====
// Constants, register map and types shared by the dual-output PWM and capture timer
package tpd_pkg;

    // AXI4-Lite register byte addresses
    localparam logic [7:0]  TPD_ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  TPD_ADDR_COUNT   = 8'h04;
    localparam logic [7:0]  TPD_ADDR_RELOAD  = 8'h08;
    localparam logic [7:0]  TPD_ADDR_MATCH   = 8'h0c;
    localparam logic [7:0]  TPD_ADDR_STATUS  = 8'h10;
    localparam logic [7:0]  TPD_ADDR_INT_CLR = 8'h14;
    localparam logic [7:0]  TPD_ADDR_INT_EN  = 8'h18;

    // Control register field positions
    localparam int          TPD_CTRL_EN_BIT   = 0;
    localparam int          TPD_CTRL_MODE_LSB = 1;
    localparam int          TPD_CTRL_POL_BIT  = 3;
    localparam int          TPD_CTRL_PRE_LSB  = 4;
    localparam int          TPD_CTRL_DB_LSB   = 8;

    // Status register field positions
    localparam int          TPD_STAT_RELOAD_BIT = 0;
    localparam int          TPD_STAT_CAPT_BIT   = 1;
    localparam int          TPD_STAT_FLAG_BIT   = 8;

    // Values after reset and counter constants
    localparam logic [15:0] TPD_COUNT_RESTART = 16'h0001;
    localparam logic [15:0] TPD_COUNT_RST     = 16'h0001;
    localparam logic [15:0] TPD_RELOAD_RST    = 16'hffff;
    localparam logic [15:0] TPD_MATCH_RST     = 16'h0000;
    localparam logic [7:0]  TPD_DB_MAX        = 8'h80;

    // AXI responses
    localparam logic [1:0]  TPD_RESP_OKAY   = 2'b00;
    localparam logic [1:0]  TPD_RESP_SLVERR = 2'b10;

    // Operating modes
    typedef enum logic [1:0] {
        TPD_MODE_PWM_SINGLE = 2'b00,
        TPD_MODE_PWM_DUAL   = 2'b01,
        TPD_MODE_CAPTURE    = 2'b11
    } tpd_mode_t;

endpackage

// ==== rtl/tpd_deadband.sv ====
// Deadband delay: holds back each low-to-high edge of one output pin
`timescale 1ns/100ps
module tpd_deadband
    import tpd_pkg::*;
#(
    parameter int DBW = 8
)(
    // Clock and reset
    input  wire logic           clock,
    input  wire logic           rst_b,
    // Level in, delay, level out
    input  wire logic           level_i,
    input  wire logic [DBW-1:0] delay_i,
    output logic                level_o
);

    typedef struct packed {
        logic [DBW-1:0] cnt;
        logic           out;
    } tpd_db_state_t;

    tpd_db_state_t s_q;
    tpd_db_state_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (!level_i)
        begin
            s_d.cnt = '0;
            s_d.out = 1'b0;
        end
        else if (!s_q.out)
        begin
            if (s_q.cnt >= delay_i)
                s_d.out = 1'b1;
            else
                s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_b)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign level_o = s_q.out;

endmodule // tpd_deadband

// ==== tb/tpd_pin_model.sv ====
// Pin-side model: drives the capture input and tallies PWM pin levels
`timescale 1ns/100ps
module tpd_pin_model (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // Timer pins
    input  wire logic pwm_out,
    input  wire logic pwm_out_n,
    output logic      timer_in
);
    int   hi;
    int   hi_n;
    int   both_lo;
    int   both_hi;
    int   bad;
    logic clr = 1'b1;

    initial timer_in = 1'b0;

    // Clear goes through a flag so it never races the tally
    always @(posedge clock)
    begin
        hi      <= (clr || !rst_b) ? 0 : hi + int'(pwm_out);
        hi_n    <= (clr || !rst_b) ? 0 : hi_n + int'(pwm_out_n);
        both_lo <= (clr || !rst_b) ? 0 : both_lo + int'(!pwm_out && !pwm_out_n);
        both_hi <= (clr || !rst_b) ? 0 : both_hi + int'(pwm_out && pwm_out_n);
        // Unknown levels would tally as zero above, so count them apart
        bad     <= (clr || !rst_b) ? 0 : bad + int'($isunknown({pwm_out, pwm_out_n}));
    end

    task clear_counts();
        @(posedge clock);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
    endtask

    task set_in(input logic v);
        @(posedge clock);
        timer_in <= v;
    endtask
endmodule // tpd_pin_model

// ==== tb/tb_tpd_timer.sv ====
// Register-level testbench for the PWM and capture timer
`timescale 1ns/100ps
module tb_tpd_timer;
    import tpd_pkg::*;
    logic        clock = 1'b0;
    logic        rst_b;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        timer_in, pwm_out, pwm_out_n, irq;
    int          fails = 0;
    int          checks_done = 0;
    int          t;
    int          c;
    int          a;

    tpd_timer DUT (.clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
        .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
        .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .timer_in, .pwm_out, .pwm_out_n, .irq);
    tpd_pin_model PIN (.clock, .rst_b, .pwm_out, .pwm_out_n, .timer_in);

    always #5 clock = ~clock;

    task chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task chk_cnt(input int got, input int exp, input string what);
        checks_done++;
        if (got != exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %0d expected %0d", $time, what, got, exp);
        end
    endtask

    // Write with address and data offered together, each released when taken
    task wr(input logic [7:0] ad, input logic [31:0] v, input logic [1:0] er = TPD_RESP_OKAY);
        int n;
        @(posedge clock);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= ad;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= v;
        s_axi_bready  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 100);
        s_axi_bready <= 1'b0;
        chk_reg({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er}, "write response");
    endtask

    task rd(input logic [7:0] ad, input logic [31:0] exp, input logic [31:0] m = 32'hffffffff,
            input logic [1:0] er = TPD_RESP_OKAY);
        int n;
        @(posedge clock);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= ad;
        s_axi_rready  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clock);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 100);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        chk_reg({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er}, "read response");
        chk_reg(d & m, exp, "read data");
    endtask

    function automatic logic [31:0] ctl(int en, int md, int pol, int pre, int db);
        return 32'(en + md * 2 + pol * 8 + pre * 16 + db * 256);
    endfunction

    task measure(input int n);
        PIN.clear_counts();
        repeat (n) @(posedge clock);
        #1;
    endtask

    task wait_pwm(input logic v, output int n);
        n = 0;
        while (pwm_out !== v && n < 5000)
        begin
            @(posedge clock);
            n++;
        end
    endtask

    task print_verdict();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        fails++;
        print_verdict();
    end

    initial
    begin
        rst_b = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        rd(TPD_ADDR_CTRL, 32'h0);
        rd(TPD_ADDR_COUNT, 32'h1);
        rd(TPD_ADDR_RELOAD, 32'hffff);
        rd(TPD_ADDR_MATCH, 32'h0);
        rd(TPD_ADDR_STATUS, 32'h0);
        rd(TPD_ADDR_INT_EN, 32'h0);
        rd(TPD_ADDR_INT_CLR, 32'h0);
        rd(8'h1c, 32'h0, 32'hffffffff, TPD_RESP_SLVERR);
        wr(8'h1c, 32'h1, TPD_RESP_SLVERR);
        wr(TPD_ADDR_CTRL, ctl(0, 0, 0, 0, 255));
        rd(TPD_ADDR_CTRL, 32'h8000);
        wr(TPD_ADDR_COUNT, 32'h5);
        repeat (20) @(posedge clock);
        rd(TPD_ADDR_COUNT, 32'h5);
        $display("test registers done");

        // Single output: reload 10, match 4, window of whole periods
        wr(TPD_ADDR_RELOAD, 32'd10);
        wr(TPD_ADDR_MATCH, 32'd4);
        for (int i = 0; i < 3; i++)
        begin
            a = (i == 1);
            wr(TPD_ADDR_CTRL, ctl(0, 0, a, i / 2, 0));
            wr(TPD_ADDR_COUNT, 32'h1);
            wr(TPD_ADDR_CTRL, ctl(1, 0, a, i / 2, 0));
            repeat (30) @(posedge clock);
            measure(40 * (1 + i / 2));
            chk_cnt(PIN.hi, (a ? 4 : 6) * 4 * (1 + i / 2), "single high time");
            chk_cnt(PIN.hi_n, 0, "complement idle");
            chk_cnt(PIN.bad, 0, "unknown pin level");
        end
        // Start at 7 with divide by 4: short first period, then full ones
        wr(TPD_ADDR_CTRL, ctl(0, 0, 0, 2, 0));
        wr(TPD_ADDR_MATCH, 32'd8);
        wr(TPD_ADDR_COUNT, 32'd7);
        wr(TPD_ADDR_CTRL, ctl(1, 0, 0, 2, 0));
        wait_pwm(1'b1, t);
        wait_pwm(1'b0, c);
        chk_reg(32'(t + c >= 13 && t + c <= 19), 32'h1, "first period");
        wait_pwm(1'b1, t);
        wait_pwm(1'b0, c);
        chk_cnt(t + c, 40, "later period");
        $display("test single done");

        // Dual output: reload 20, match 8, both polarities and deadbands
        wr(TPD_ADDR_RELOAD, 32'd20);
        for (int i = 0; i < 2; i++)
        begin
            c = 3 * (1 - i);
            a = i ? 12 : 8;
            wr(TPD_ADDR_CTRL, ctl(0, 1, 1 - i, 0, c));
            wr(TPD_ADDR_COUNT, 32'h1);
            wr(TPD_ADDR_CTRL, ctl(1, 1, 1 - i, 0, c));
            repeat (30) @(posedge clock);
            measure(80);
            chk_cnt(PIN.hi, 4 * (a - c), "dual high time");
            chk_cnt(PIN.hi_n, 4 * (20 - a - c), "complement high time");
            chk_cnt(PIN.both_hi, 0, "overlap");
            chk_cnt(PIN.both_lo, 8 * c, "dead time");
            chk_cnt(PIN.bad, 0, "unknown pin level");
        end
        rd(TPD_ADDR_STATUS, 32'h1, 32'h1);
        $display("test dual done");

        // Disable, mode, start count, reload, cleared match
        wr(TPD_ADDR_CTRL, ctl(0, 3, 0, 7, 0));
        wr(TPD_ADDR_COUNT, 32'h1);
        wr(TPD_ADDR_RELOAD, 32'd6);
        wr(TPD_ADDR_MATCH, 32'h0);
        wr(TPD_ADDR_INT_CLR, 32'h3);
        wr(TPD_ADDR_INT_EN, 32'h3);
        wr(TPD_ADDR_CTRL, ctl(1, 3, 0, 7, 0));
        repeat (448) @(posedge clock);
        PIN.set_in(1'b1);
        rd(TPD_ADDR_MATCH, 32'd4);
        rd(TPD_ADDR_STATUS, 32'h102, 32'h103);
        chk_reg({31'h0, irq}, 32'h1, "irq on capture");
        wr(TPD_ADDR_INT_EN, 32'h0);
        chk_reg({31'h0, irq}, 32'h0, "irq masked");
        wr(TPD_ADDR_INT_EN, 32'h3);
        wr(TPD_ADDR_INT_CLR, 32'h3);
        chk_reg({31'h0, irq}, 32'h0, "irq cleared");
        rd(TPD_ADDR_STATUS, 32'h100, 32'h103);
        wr(TPD_ADDR_MATCH, 32'h0);
        PIN.set_in(1'b0);
        repeat (400) @(posedge clock);
        rd(TPD_ADDR_MATCH, 32'h0);
        rd(TPD_ADDR_STATUS, 32'h1, 32'h103);
        chk_reg({31'h0, irq}, 32'h1, "irq on reload");
        wr(TPD_ADDR_INT_CLR, 32'h3);
        wr(TPD_ADDR_CTRL, ctl(1, 3, 1, 7, 0));
        PIN.set_in(1'b1);
        repeat (4) @(posedge clock);
        rd(TPD_ADDR_STATUS, 32'h0, 32'h2);
        PIN.set_in(1'b0);
        repeat (4) @(posedge clock);
        rd(TPD_ADDR_STATUS, 32'h102, 32'h102);
        rd(TPD_ADDR_MATCH, 32'h0, 32'hffff0000);
        chk_reg(32'(d[15:0] != 16'h0), 32'h1, "falling capture");
        $display("test capture done");
        print_verdict();
    end
endmodule // tb_tpd_timer
